//--- core/gpp_port.sv
// Purpose: General digital I/O port with direction, latch and pin sample
// Assumes: Accesses are single-cycle strobes synchronous to clk
// Notes: Pull-up disable is shared by all ports and enters as a level
`timescale 1ns/10ps
module gpp_port (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register access port
   input wire gpp_pkg::gpp_access_s access,
   output logic [7:0] rdData,
   // Global controls
   input wire logic global_pullup_disable,
   input wire logic sleepClamp,
   input wire logic [7:0] clampOverride,
   // Pins
   input wire logic [7:0] padIn,
   output gpp_pkg::gpp_pad_s pad
);
   logic [7:0] output_latch_reg;
   logic [7:0] direction_reg;
   logic [7:0] pin_sample_reg;
   logic [7:0] next_latch;
   logic [7:0] next_dir;
   logic [7:0] next_rdData;
   logic [7:0] bitMask;
   logic [7:0] gatedIn;
   // Select code that reaches no register
   localparam logic [1:0] SelUnmapped = 2'h3;

   // Register update, whole byte or single bit
   always_comb begin
      next_latch = output_latch_reg;
      next_dir = direction_reg;
      bitMask = 8'h01 << access.bitIdx;
      if (access.wrEn) begin
         unique case (access.sel)
            gpp_pkg::SEL_LATCH: next_latch = access.wrData;
            gpp_pkg::SEL_DIR: next_dir = access.wrData;
            gpp_pkg::SEL_PIN: next_latch = output_latch_reg ^ access.wrData;
            default: next_latch = output_latch_reg;
         endcase
      end else if (access.setBit) begin
         unique case (access.sel)
            gpp_pkg::SEL_LATCH: next_latch = output_latch_reg | bitMask;
            gpp_pkg::SEL_DIR: next_dir = direction_reg | bitMask;
            gpp_pkg::SEL_PIN: next_latch = output_latch_reg ^ bitMask;
            default: next_latch = output_latch_reg;
         endcase
      end else if (access.clrBit) begin
         unique case (access.sel)
            gpp_pkg::SEL_LATCH: next_latch = output_latch_reg & ~bitMask;
            gpp_pkg::SEL_DIR: next_dir = direction_reg & ~bitMask;
            default: next_latch = output_latch_reg;
         endcase
      end
   end

   // Registers clear to input without pull-up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         output_latch_reg <= gpp_pkg::LATCH_RESET;
         direction_reg <= gpp_pkg::DIR_RESET;
      end else begin
         output_latch_reg <= next_latch;
         direction_reg <= next_dir;
      end
   end

   // Pad control, forced off by reset with no clock
   always_comb begin
      pad.padOut = output_latch_reg;
      pad.padOe = rst_n ? direction_reg : 8'h00;
      pad.pullupEn = (rst_n && !global_pullup_disable) ?
         (~direction_reg & output_latch_reg) : 8'h00;
   end

   // Sleep clamp ahead of the synchroniser
   always_comb begin
      gatedIn = padIn & ~({8{sleepClamp}} & ~clampOverride);
   end

   // Per-pin synchronisers; each pin independent
   genvar gi;
   generate
      for (gi = 0; gi < gpp_pkg::PORT_WIDTH; gi++) begin : g_sync
         gpp_sync_bit u_sync (
            .clk(clk),
            .rst_n(rst_n),
            .padIn(gatedIn[gi]),
            .sample(pin_sample_reg[gi])
         );
      end
   endgenerate

   // Registered read data
   always_comb begin
      unique case (access.sel)
         gpp_pkg::SEL_PIN: next_rdData = pin_sample_reg;
         gpp_pkg::SEL_DIR: next_rdData = direction_reg;
         gpp_pkg::SEL_LATCH: next_rdData = output_latch_reg;
         default: next_rdData = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= gpp_pkg::SAMPLE_RESET;
      end else begin
         rdData <= next_rdData;
      end
   end

   // Pull-up never on an output
   pull_output_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pad.pullupEn & direction_reg) == 8'h00) else $error("pull-up on output");
   pullup_disable_a: assert property (@(posedge clk) disable iff (!rst_n)
      global_pullup_disable |-> pad.pullupEn == 8'h00) else $error("pull-up despite disable");
   pin_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.wrEn && access.sel == gpp_pkg::SEL_PIN) |=>
      output_latch_reg == ($past(output_latch_reg) ^ $past(access.wrData)))
      else $error("toggle wrong");
   bit_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!access.wrEn && access.setBit && access.sel == gpp_pkg::SEL_DIR) |=>
      direction_reg == ($past(direction_reg) | (8'h01 << $past(access.bitIdx))))
      else $error("bit set wrong");
   bit_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!access.wrEn && !access.setBit && access.clrBit && access.sel == gpp_pkg::SEL_LATCH) |=>
      output_latch_reg == ($past(output_latch_reg) & ~(8'h01 << $past(access.bitIdx))))
      else $error("bit clear wrong");
   drive_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
      pad.padOe == direction_reg && pad.padOut == output_latch_reg)
      else $error("drive mismatch");
   pullup_in_a: assert property (@(posedge clk) disable iff (!rst_n)
      !global_pullup_disable |-> pad.pullupEn == (~direction_reg & output_latch_reg))
      else $error("pull-up wrong");
   sample_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
      $stable(gatedIn) ##1 $stable(gatedIn) |=> pin_sample_reg == $past(gatedIn))
      else $error("sample late");

   // Byte writes land as written
   latch_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.wrEn && access.sel == gpp_pkg::SEL_LATCH) |=>
      output_latch_reg == $past(access.wrData))
      else $error("latch write lost");
   dir_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.wrEn && access.sel == gpp_pkg::SEL_DIR) |=>
      direction_reg == $past(access.wrData))
      else $error("direction write lost");

   // Unmapped select changes no register
   unmapped_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.sel == SelUnmapped) |=>
      ($stable(output_latch_reg) && $stable(direction_reg)))
      else $error("unmapped access changed state");

   // Clear on the sample register is ignored
   pin_clr_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!access.wrEn && !access.setBit && access.clrBit && access.sel == gpp_pkg::SEL_PIN) |=>
      ($stable(output_latch_reg) && $stable(direction_reg)))
      else $error("pin clear had effect");

   // Single-bit set on the sample register toggles one latch bit
   pin_set_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!access.wrEn && access.setBit && access.sel == gpp_pkg::SEL_PIN) |=>
      output_latch_reg == ($past(output_latch_reg) ^ (8'h01 << $past(access.bitIdx))))
      else $error("pin bit toggle wrong");

   // Single-bit latch set and direction clear touch one bit
   latch_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!access.wrEn && access.setBit && access.sel == gpp_pkg::SEL_LATCH) |=>
      output_latch_reg == ($past(output_latch_reg) | (8'h01 << $past(access.bitIdx))))
      else $error("latch bit set wrong");
   dir_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!access.wrEn && !access.setBit && access.clrBit && access.sel == gpp_pkg::SEL_DIR) |=>
      direction_reg == ($past(direction_reg) & ~(8'h01 << $past(access.bitIdx))))
      else $error("direction bit clear wrong");

   // Direction moves only when selected; latch holds while direction is selected
   dir_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.sel != gpp_pkg::SEL_DIR) |=> $stable(direction_reg))
      else $error("direction moved unselected");
   latch_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.sel == gpp_pkg::SEL_DIR) |=> $stable(output_latch_reg))
      else $error("latch moved unselected");

   // Read data follows the select one cycle later
   read_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.sel == gpp_pkg::SEL_DIR) |=> rdData == $past(direction_reg))
      else $error("direction read wrong");
   read_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.sel == gpp_pkg::SEL_PIN) |=> rdData == $past(pin_sample_reg))
      else $error("pin read wrong");
   read_none_a: assert property (@(posedge clk) disable iff (!rst_n)
      (access.sel == SelUnmapped) |=> rdData == 8'h00)
      else $error("unmapped read not zero");

   // Clamp forces unexempted inputs low, passes all when awake
   clamp_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      sleepClamp |-> (gatedIn & ~clampOverride) == 8'h00)
      else $error("clamp leaked");
   clamp_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sleepClamp |-> gatedIn == padIn)
      else $error("input gated while awake");

   // Reset holds pins released and registers cleared
   reset_float_a: assert property (@(posedge clk)
      !rst_n |-> (pad.padOe == 8'h00 && pad.pullupEn == 8'h00))
      else $error("pin driven in reset");
   reset_clear_a: assert property (@(posedge clk)
      !rst_n |-> (output_latch_reg == gpp_pkg::LATCH_RESET &&
      direction_reg == gpp_pkg::DIR_RESET))
      else $error("registers not cleared in reset");
endmodule

//--- core/gpp_pkg.sv
// Purpose: Shared constants and types for the general digital I/O port
// Assumes: One 8-bit port, registers reached by a simple I/O access port
// Notes: Register selects are local indices on the I/O access port
package gpp_pkg;
   localparam int PORT_WIDTH = 8;
   localparam logic [1:0] SEL_PIN = 2'h0;
   localparam logic [1:0] SEL_DIR = 2'h1;
   localparam logic [1:0] SEL_LATCH = 2'h2;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] SAMPLE_RESET = 8'h00;
   localparam logic [2:0] BIT_IDX_W = 3'h7;

   // One register access from the processor side
   typedef struct packed {
      logic wrEn;
      logic setBit;
      logic clrBit;
      logic [1:0] sel;
      logic [2:0] bitIdx;
      logic [7:0] wrData;
   } gpp_access_s;

   // Pad control for the whole port
   typedef struct packed {
      logic [7:0] padOut;
      logic [7:0] padOe;
      logic [7:0] pullupEn;
   } gpp_pad_s;
endpackage

//--- core/gpp_sync_bit.sv
// Purpose: One pin input synchroniser: high-phase latch then rising-edge flop
// Assumes: clk is the I/O clock
// Notes: Latch is transparent while clk is high
`timescale 1ns/10ps
module gpp_sync_bit (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin level and sampled bit
   input wire logic padIn,
   output logic sample
);
   logic syncLatch;
   logic next_sample;

   // Latch stage, closed while clock is low
   always_latch begin
      if (!rst_n) begin
         syncLatch = 1'b0;
      end else if (clk) begin
         syncLatch = padIn;
      end
   end

   // Second stage reads only the latch
   always_comb begin
      next_sample = syncLatch;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample <= 1'b0;
      end else begin
         sample <= next_sample;
      end
   end
endmodule

//--- dv/gpp_pin_model.sv
// Purpose: Board around the port pins
// Assumes: Port driver wins over board drive
// Notes: A floating pin shows the inverse of the level the port last drove
`timescale 1ns/10ps
module gpp_pin_model (
   // From the port
   input wire gpp_pkg::gpp_pad_s pad,
   // Board drive
   input wire logic [7:0] extVal,
   input wire logic [7:0] extEn,
   // Pin levels
   output logic [7:0] pinLvl
);
   logic [7:0] lastDrv = 8'h00;
   // Remember the level the port last drove
   always @(pad) begin
      for (int i = 0; i < 8; i++) begin
         if (pad.padOe[i]) lastDrv[i] = pad.padOut[i];
      end
   end
   // Resolve each pin; a floating pin shows the inverse of its last drive
   always @(pad or extVal or extEn or lastDrv) begin
      for (int i = 0; i < 8; i++) begin
         if (pad.padOe[i]) pinLvl[i] = pad.padOut[i];
         else if (extEn[i]) pinLvl[i] = extVal[i];
         else if (pad.pullupEn[i]) pinLvl[i] = 1'b1;
         else pinLvl[i] = ~lastDrv[i];
      end
   end
endmodule

//--- dv/tb_general_digital_io_port.sv
// Purpose: Self-checking bench for the port
// Assumes: Reads return one cycle after the select
// Notes: Board drives pins 3 and 6
`timescale 1ns/10ps
module tb_general_digital_io_port;
   logic clk = 0;
   logic rst_n;
   gpp_pkg::gpp_access_s access = '0;
   logic pullOff = 0;
   logic slp = 0;
   logic [7:0] ovr = 8'h00;
   logic [7:0] extVal = 8'h40;
   logic [7:0] extEn = 8'h48;
   logic [7:0] rdData, pinLvl, v;
   gpp_pkg::gpp_pad_s pad;
   int n_errors = 0;
   int checked = 0;
   // Clock
   always #5 clk = ~clk;
   gpp_port DUT (.clk(clk), .rst_n(rst_n), .access(access), .rdData(rdData),
      .global_pullup_disable(pullOff), .sleepClamp(slp), .clampOverride(ovr),
      .padIn(pinLvl), .pad(pad));
   gpp_pin_model PINS (.pad(pad), .extVal(extVal), .extEn(extEn), .pinLvl(pinLvl));
   // Compare and count
   task chk(string nm, logic [7:0] got, logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // One access: 0 write, 1 set, 2 clear, 3 read
   task acc(logic [1:0] k, logic [1:0] sel, logic [7:0] d);
      @(posedge clk);
      access <= '{k == 0, k == 1, k == 2, sel, d[2:0], d};
   endtask
   task rd(logic [1:0] sel);
      acc(3, sel, 8'h00);
      acc(3, 2'h0, 8'h00);
      #1 v = rdData;
   endtask
   // Reset state
   task t_reset;
      chk("oe", pad.padOe, 8'h00);
      chk("pu", pad.pullupEn, 8'h00);
      rd(gpp_pkg::SEL_DIR);
      chk("dir", v, 8'h00);
      rd(gpp_pkg::SEL_LATCH);
      chk("latch", v, 8'h00);
      $display("reset done");
   endtask
   // Byte writes, toggle, unmapped
   task t_regs;
      acc(0, gpp_pkg::SEL_DIR, 8'hA5);
      acc(0, gpp_pkg::SEL_LATCH, 8'h3C);
      acc(0, gpp_pkg::SEL_PIN, 8'h0F);
      acc(0, 2'h3, 8'hFF);
      rd(gpp_pkg::SEL_DIR);
      chk("dir", v, 8'hA5);
      rd(gpp_pkg::SEL_LATCH);
      chk("latch", v, 8'h33);
      rd(2'h3);
      chk("unmapped", v, 8'h00);
      chk("oe", pad.padOe, 8'hA5);
      chk("out", pad.padOut, 8'h33);
      chk("pu", pad.pullupEn, 8'h12);
      rd(gpp_pkg::SEL_PIN);
      chk("pin", v, 8'h73);
      $display("regs done");
   endtask
   // Single-bit set and clear
   task t_bits;
      acc(1, gpp_pkg::SEL_DIR, 8'h06);
      acc(2, gpp_pkg::SEL_LATCH, 8'h05);
      acc(2, gpp_pkg::SEL_PIN, 8'h00);
      acc(1, gpp_pkg::SEL_PIN, 8'h01);
      rd(gpp_pkg::SEL_DIR);
      chk("dir", v, 8'hE5);
      rd(gpp_pkg::SEL_LATCH);
      chk("latch", v, 8'h11);
      chk("pu", pad.pullupEn, 8'h10);
      @(posedge clk) pullOff <= 1;
      #1 chk("pullOff", pad.pullupEn, 8'h00);
      @(posedge clk) pullOff <= 0;
      $display("bits done");
   endtask
   // Input path, readback, clamp
   task t_input;
      @(posedge clk) extVal <= 8'h08;
      rd(gpp_pkg::SEL_PIN);
      chk("ext", v & 8'h08, 8'h08);
      acc(0, gpp_pkg::SEL_LATCH, 8'hE5);
      acc(3, 2'h0, 8'h00);
      rd(gpp_pkg::SEL_PIN);
      chk("back", v & 8'hE5, 8'hE5);
      @(posedge clk) slp <= 1;
      ovr <= 8'h01;
      rd(gpp_pkg::SEL_PIN);
      chk("clamp", v, 8'h01);
      slp <= 0;
      $display("input done");
   endtask
   // Reset in mid-run
   task t_midreset;
      @(posedge clk) rst_n <= 0;
      #1 chk("oe", pad.padOe, 8'h00);
      @(posedge clk) rst_n <= 1;
      rd(gpp_pkg::SEL_LATCH);
      chk("latch", v, 8'h00);
      $display("midreset done");
   endtask
   // Direction changes through the allowed intermediate states
   task t_switch;
      acc(1, gpp_pkg::SEL_LATCH, 8'h00);
      acc(3, 2'h0, 8'h00);
      #1 chk("pu0", pad.pullupEn, 8'h01);
      acc(1, gpp_pkg::SEL_DIR, 8'h00);
      acc(3, 2'h0, 8'h00);
      #1 chk("oe0", pad.padOe, 8'h01);
      chk("pu0off", pad.pullupEn, 8'h00);
      acc(1, gpp_pkg::SEL_LATCH, 8'h01);
      acc(3, 2'h0, 8'h00);
      #1 chk("pu1", pad.pullupEn, 8'h02);
      acc(2, gpp_pkg::SEL_LATCH, 8'h01);
      acc(3, 2'h0, 8'h00);
      #1 chk("tri1", pad.pullupEn, 8'h00);
      acc(1, gpp_pkg::SEL_DIR, 8'h01);
      acc(3, 2'h0, 8'h00);
      #1 chk("oe1", pad.padOe, 8'h03);
      rd(gpp_pkg::SEL_PIN);
      chk("lvl", v & 8'h03, 8'h01);
      $display("switch done");
   endtask
   // Verdict
   task test_done;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_n <= 0;
      repeat (4) @(posedge clk);
      rst_n <= 1;
      t_reset;
      t_regs;
      t_bits;
      t_input;
      t_midreset;
      t_switch;
      test_done;
   end
endmodule
